// ---- src/ffsrc_defines.svh ----
// register offsets, field positions and constants of the flat field source
`ifndef FFSRC_DEFINES_SVH
`define FFSRC_DEFINES_SVH

`define OFF_CTRL        8'h00
`define OFF_PRESET      8'h04
`define OFF_STATUS      8'h08
`define OFF_TC_OUT      8'h0c
`define OFF_IRQ_STATUS  8'h10
`define OFF_IRQ_MASK    8'h14

`define CTRL_MODE_LSB   0
`define CTRL_MODE_MSB   1
`define CTRL_FMT_LSB    2
`define CTRL_FMT_MSB    6
`define CTRL_COLOR_LSB  7
`define CTRL_COLOR_MSB  10
`define CTRL_PASS_BIT   11
`define CTRL_DOWN_BIT   12
`define CTRL_HOLD_BIT   13
`define CTRL_INS_BIT    14
`define CTRL_WIDTH      15
`define CTRL_RESET      15'h0000

`define PRESET_LOAD_BIT 31
`define TC_WIDTH        23

`define IRQ_FLAT_BIT    0
`define IRQ_LOSS_BIT    1
`define IRQ_FAIL_BIT    2
`define IRQ_WIDTH       3

`define HOUR_LAST       5'h17
`define MIN_LAST        6'h3b
`define SEC_LAST        6'h3b
`define COLOR_COUNT     4'h9

`endif

// ---- src/ffsrc_pkg.sv ----
// types shared by the flat field and timecode source
`default_nettype none
package ffsrc_pkg;
	typedef enum logic [1:0] {
		FLAT_OFF     = 2'b00,
		FLAT_MANUAL  = 2'b01,
		FLAT_ON_LOSS = 2'b10,
		FLAT_RSVD    = 2'b11
	} flat_mode_t;

	typedef enum logic [1:0] {
		SRC_NONE     = 2'b00,
		SRC_INPUT    = 2'b01,
		SRC_FREE_RUN = 2'b10
	} tc_src_t;

	typedef struct packed {
		logic [4:0] hours;
		logic [5:0] minutes;
		logic [5:0] seconds;
		logic [5:0] frames;
	} timecode_t;
endpackage
`default_nettype wire

// ---- src/flat_field_and_timecode_source.sv ----
// flat field insertion and timecode source selection for one video path
//
// The address map and register access over AHB-Lite were left to the implementer.
`default_nettype none
`include "ffsrc_defines.svh"

module flat_field_and_timecode_source #(
	parameter int         VIDEO_WIDTH = 20,
	parameter logic [5:0] FRAME_LAST  = 6'h1d
) (
	input  wire logic                     hclk,
	input  wire logic                     hresetn,
	input  wire logic                     hsel,
	input  wire logic [31:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output logic                          hreadyout,
	output logic                          hresp,
	output logic [31:0]                   hrdata,
	input  wire logic [VIDEO_WIDTH-1:0]   vid_in_data,
	input  wire logic                     vid_in_valid,
	input  wire logic                     rx_locked,
	input  wire logic                     rx_format_known,
	input  wire logic [4:0]               rx_format,
	input  wire logic                     frame_tick,
	input  wire logic                     ext_tc_valid,
	input  wire ffsrc_pkg::timecode_t     ext_tc,
	output logic [VIDEO_WIDTH-1:0]        vid_out_data,
	output logic                          vid_out_valid,
	output logic [4:0]                    vid_out_format,
	output logic                          flat_active,
	output ffsrc_pkg::timecode_t          tc_out,
	output ffsrc_pkg::tc_src_t            tc_source,
	output logic                          irq
);
	import ffsrc_pkg::*;

	localparam int HALF = VIDEO_WIDTH / 2;

	// configuration and interrupt state
	logic [`CTRL_WIDTH-1:0] ctrl, next_ctrl;
	logic [`IRQ_WIDTH-1:0]  irq_status, next_irq_status;
	logic [`IRQ_WIDTH-1:0]  irq_mask, next_irq_mask;
	timecode_t              preset, next_preset;
	logic [31:0]            next_hrdata;
	logic [7:0]             wr_addr, next_wr_addr;
	logic                   wr_pend, next_wr_pend;

	// datapath state
	timecode_t              counter, next_counter;
	timecode_t              last_ext, next_last_ext;
	timecode_t              next_tc_out;
	tc_src_t                next_tc_source;
	logic [VIDEO_WIDTH-1:0] next_vid_out_data;
	logic                   next_vid_out_valid;
	logic [4:0]             next_vid_out_format;
	logic                   next_flat_active;
	logic                   input_lost_d, next_input_lost_d;
	logic                   ext_lost_d, next_ext_lost_d;

	flat_mode_t  mode;
	logic [4:0]  cfg_format;
	logic [3:0]  cfg_color;
	logic        passthrough;
	logic        count_down;
	logic        hold_at_zero;
	logic        insert_en;
	logic        input_lost;
	logic        ext_lost;
	logic        free_running;
	logic        flat_now;
	logic        addr_phase;
	logic        wr_now;
	logic        preset_load;
	logic [`IRQ_WIDTH-1:0] irq_events;
	timecode_t   stepped;

	assign mode         = flat_mode_t'(ctrl[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
	assign cfg_format   = ctrl[`CTRL_FMT_MSB:`CTRL_FMT_LSB];
	assign cfg_color    = ctrl[`CTRL_COLOR_MSB:`CTRL_COLOR_LSB];
	assign passthrough  = ctrl[`CTRL_PASS_BIT];
	assign count_down   = ctrl[`CTRL_DOWN_BIT];
	assign hold_at_zero = ctrl[`CTRL_HOLD_BIT];
	assign insert_en    = ctrl[`CTRL_INS_BIT];

	// zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	assign input_lost = !(rx_locked && rx_format_known);
	// the reserved mode code behaves as disabled
	assign flat_now   = (mode == FLAT_MANUAL) ||
	                    (mode == FLAT_ON_LOSS && input_lost);

	assign ext_lost     = passthrough && !ext_tc_valid;
	assign free_running = !passthrough || ext_lost;

	assign addr_phase  = hsel && htrans[1] && hready;
	assign wr_now      = wr_pend;
	assign preset_load = wr_now && wr_addr == `OFF_PRESET &&
	                     hwdata[`PRESET_LOAD_BIT];

	// ycbcr level pairs for the nine colours; out of range codes give black
	function automatic logic [VIDEO_WIDTH-1:0] colour(input logic [3:0] c);
		logic [HALF-1:0] y;
		logic [HALF-1:0] cx;
		y  = HALF'(64);
		cx = HALF'(512);
		unique case (c)
			4'h0: begin y = HALF'(64);  cx = HALF'(512); end // black
			4'h1: begin y = HALF'(940); cx = HALF'(512); end // white
			4'h2: begin y = HALF'(502); cx = HALF'(512); end // grey
			4'h3: begin y = HALF'(250); cx = HALF'(409); end // red
			4'h4: begin y = HALF'(691); cx = HALF'(167); end // green
			4'h5: begin y = HALF'(127); cx = HALF'(960); end // blue
			4'h6: begin y = HALF'(877); cx = HALF'(64);  end // yellow
			4'h7: begin y = HALF'(754); cx = HALF'(615); end // cyan
			4'h8: begin y = HALF'(314); cx = HALF'(857); end // magenta
			default: begin y = HALF'(64); cx = HALF'(512); end
		endcase
		return {y, cx};
	endfunction

	// one frame step of the internal counter
	always_comb begin
		stepped = counter;
		if (count_down) begin
			if (counter.frames != 6'h00) begin
				stepped.frames = counter.frames - 6'h01;
			end else if (counter.seconds != 6'h00) begin
				stepped.frames  = FRAME_LAST;
				stepped.seconds = counter.seconds - 6'h01;
			end else if (counter.minutes != 6'h00) begin
				stepped.frames  = FRAME_LAST;
				stepped.seconds = `SEC_LAST;
				stepped.minutes = counter.minutes - 6'h01;
			end else if (counter.hours != 5'h00) begin
				stepped.frames  = FRAME_LAST;
				stepped.seconds = `SEC_LAST;
				stepped.minutes = `MIN_LAST;
				stepped.hours   = counter.hours - 5'h01;
			end else if (!hold_at_zero) begin
				stepped.frames  = FRAME_LAST;
				stepped.seconds = `SEC_LAST;
				stepped.minutes = `MIN_LAST;
				stepped.hours   = `HOUR_LAST;
			end
		end else begin
			// frames past the rate limit (after a preset) also roll over
			if (counter.frames < FRAME_LAST) begin
				stepped.frames = counter.frames + 6'h01;
			end else begin
				stepped.frames = 6'h00;
				if (counter.seconds < `SEC_LAST) begin
					stepped.seconds = counter.seconds + 6'h01;
				end else begin
					stepped.seconds = 6'h00;
					if (counter.minutes < `MIN_LAST) begin
						stepped.minutes = counter.minutes + 6'h01;
					end else begin
						stepped.minutes = 6'h00;
						if (counter.hours < `HOUR_LAST) begin
							stepped.hours = counter.hours + 5'h01;
						end else begin
							stepped.hours = 5'h00;
						end
					end
				end
			end
		end
	end

	// timecode source, counter and video path
	always_comb begin
		next_last_ext = last_ext;
		if (ext_tc_valid) begin
			next_last_ext = ext_tc;
		end
		next_counter = counter;
		if (passthrough && ext_tc_valid) begin
			// shadow the input so the counter is already seeded on loss
			next_counter = ext_tc;
		end else if (ext_lost && !ext_lost_d) begin
			next_counter = last_ext;
		end else if (preset_load && free_running) begin
			// the start value rides in the same write as its load bit
			next_counter = timecode_t'(hwdata[`TC_WIDTH-1:0]);
		end else if (frame_tick && free_running) begin
			next_counter = stepped;
		end

		if (!insert_en) begin
			next_tc_source = SRC_NONE;
		end else if (free_running) begin
			next_tc_source = SRC_FREE_RUN;
		end else begin
			next_tc_source = SRC_INPUT;
		end
		// passed-through timecode bypasses the counter untouched
		next_tc_out = free_running ? counter : ext_tc;

		next_flat_active = flat_now;
		if (flat_now) begin
			next_vid_out_data   = colour(cfg_color);
			next_vid_out_valid  = 1'b1;
			next_vid_out_format = cfg_format;
		end else begin
			next_vid_out_data   = vid_in_data;
			next_vid_out_valid  = vid_in_valid;
			next_vid_out_format = rx_format;
		end
		next_input_lost_d = input_lost;
		next_ext_lost_d   = ext_lost;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			counter        <= '0;
			last_ext       <= '0;
			tc_out         <= '0;
			tc_source      <= SRC_NONE;
			vid_out_data   <= '0;
			vid_out_valid  <= 1'b0;
			vid_out_format <= '0;
			flat_active    <= 1'b0;
			input_lost_d   <= 1'b0;
			ext_lost_d     <= 1'b0;
		end else begin
			counter        <= next_counter;
			last_ext       <= next_last_ext;
			tc_out         <= next_tc_out;
			tc_source      <= next_tc_source;
			vid_out_data   <= next_vid_out_data;
			vid_out_valid  <= next_vid_out_valid;
			vid_out_format <= next_vid_out_format;
			flat_active    <= next_flat_active;
			input_lost_d   <= next_input_lost_d;
			ext_lost_d     <= next_ext_lost_d;
		end
	end

	assign irq_events[`IRQ_FLAT_BIT] = flat_now && !flat_active;
	assign irq_events[`IRQ_LOSS_BIT] = input_lost && !input_lost_d;
	assign irq_events[`IRQ_FAIL_BIT] = ext_lost && !ext_lost_d;

	// bus slave and registers
	always_comb begin
		next_ctrl     = ctrl;
		next_preset   = preset;
		next_irq_mask = irq_mask;
		next_wr_pend  = addr_phase && hwrite;
		next_wr_addr  = addr_phase ? haddr[7:0] : wr_addr;
		// a new event wins over a clear in the same cycle
		next_irq_status = irq_status;
		if (wr_now && wr_addr == `OFF_IRQ_STATUS) begin
			next_irq_status = irq_status & ~hwdata[`IRQ_WIDTH-1:0];
		end
		next_irq_status = next_irq_status | irq_events;
		if (wr_now) begin
			unique case (wr_addr)
				`OFF_CTRL: next_ctrl = hwdata[`CTRL_WIDTH-1:0];
				`OFF_PRESET: next_preset = hwdata[`TC_WIDTH-1:0];
				`OFF_IRQ_MASK: next_irq_mask = hwdata[`IRQ_WIDTH-1:0];
				default: ;
			endcase
		end
		next_hrdata = hrdata;
		if (addr_phase && !hwrite) begin
			unique case (haddr[7:0])
				`OFF_CTRL: next_hrdata = 32'(ctrl);
				`OFF_PRESET: next_hrdata = 32'(preset);
				`OFF_STATUS: next_hrdata = {22'h000000, tc_source,
				                            rx_format, rx_format_known,
				                            rx_locked, flat_active};
				`OFF_TC_OUT: next_hrdata = 32'(tc_out);
				`OFF_IRQ_STATUS: next_hrdata = 32'(irq_status);
				`OFF_IRQ_MASK: next_hrdata = 32'(irq_mask);
				default: next_hrdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl       <= `CTRL_RESET;
			preset     <= '0;
			irq_mask   <= '0;
			irq_status <= '0;
			hrdata     <= 32'h00000000;
			wr_pend    <= 1'b0;
			wr_addr    <= 8'h00;
		end else begin
			ctrl       <= next_ctrl;
			preset     <= next_preset;
			irq_mask   <= next_irq_mask;
			irq_status <= next_irq_status;
			hrdata     <= next_hrdata;
			wr_pend    <= next_wr_pend;
			wr_addr    <= next_wr_addr;
		end
	end

	assign irq = |(irq_status & irq_mask);

endmodule // flat_field_and_timecode_source
`default_nettype wire

// ---- test/ffsrc_monitor.sv ----
// port checks for the flat field and timecode source
`default_nettype none
module ffsrc_monitor #(
	parameter int         VIDEO_WIDTH = 20,
	parameter logic [5:0] FRAME_LAST  = 6'h1d
) (
	input wire logic                   hclk,
	input wire logic                   hresetn,
	input wire logic [VIDEO_WIDTH-1:0] vid_in_data,
	input wire logic                   vid_in_valid,
	input wire logic [VIDEO_WIDTH-1:0] vid_out_data,
	input wire logic                   vid_out_valid,
	input wire logic                   flat_active,
	input wire logic                   ext_tc_valid,
	input wire ffsrc_pkg::timecode_t   ext_tc,
	input wire ffsrc_pkg::timecode_t   tc_out,
	input wire ffsrc_pkg::tc_src_t     tc_source
);
	timeunit 1ns;
	timeprecision 1ps;
	import ffsrc_pkg::*;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_pass_data: assert property (
		$past(hresetn) && !flat_active |-> vid_out_data == $past(vid_in_data))
		else $error("input video not passed");
	a_pass_valid: assert property (
		$past(hresetn) && !flat_active |-> vid_out_valid == $past(vid_in_valid))
		else $error("input valid not passed");
	a_flat_valid: assert property (flat_active |-> vid_out_valid)
		else $error("flat field without valid");
	a_src_legal: assert property (
		tc_source inside {SRC_NONE, SRC_INPUT, SRC_FREE_RUN}
		&& (tc_source != SRC_INPUT || $past(ext_tc_valid)))
		else $error("unknown timecode source code");
	a_pass_follow: assert property (
		tc_source == SRC_INPUT |-> tc_out == $past(ext_tc))
		else $error("passed timecode differs from input");
	a_tc_range: assert property (tc_out.hours <= 5'h17
		&& tc_out.minutes <= 6'h3b && tc_out.seconds <= 6'h3b
		&& tc_out.frames <= FRAME_LAST)
		else $error("timecode out of range");
	a_src_switch: assert property (
		$fell(ext_tc_valid) && tc_source == SRC_INPUT
		|-> ##[1:3] tc_source == SRC_FREE_RUN)
		else $error("no failover to free run");
	a_seed_last: assert property (
		$fell(ext_tc_valid) && tc_source == SRC_INPUT
		|-> ##2 tc_out == $past(ext_tc, 3))
		else $error("failover not seeded from last count");
endmodule // ffsrc_monitor
bind flat_field_and_timecode_source ffsrc_monitor #(
	.VIDEO_WIDTH(VIDEO_WIDTH), .FRAME_LAST(FRAME_LAST)) mon_i (
	.hclk(hclk), .hresetn(hresetn), .vid_in_data(vid_in_data),
	.vid_in_valid(vid_in_valid), .vid_out_data(vid_out_data),
	.vid_out_valid(vid_out_valid), .flat_active(flat_active),
	.ext_tc_valid(ext_tc_valid), .ext_tc(ext_tc), .tc_out(tc_out),
	.tc_source(tc_source));
`default_nettype wire

// ---- test/ffsrc_partner.sv ----
// behavioural receiver and external timecode source facing the block
`default_nettype none
module ffsrc_partner #(
	parameter logic [4:0] FMT = 5'h05
) (
	input  wire logic            hclk,
	input  wire logic            hresetn,
	input  wire logic            lock,
	input  wire logic            tc_en,
	input  wire logic            tick_req,
	output logic [19:0]          vid_in_data,
	output logic                 vid_in_valid,
	output logic                 rx_locked,
	output logic                 rx_format_known,
	output logic [4:0]           rx_format,
	output logic                 frame_tick,
	output logic                 ext_tc_valid,
	output ffsrc_pkg::timecode_t ext_tc
);
	timeunit 1ns;
	timeprecision 1ps;
	import ffsrc_pkg::*;
	timecode_t tc;
	// an invalid source shows the inverse so a stale count never matches
	assign ext_tc = tc_en ? tc : ~tc;
	assign ext_tc_valid = tc_en;
	assign rx_locked = lock;
	assign rx_format_known = lock;
	assign vid_in_valid = lock;
	assign rx_format = FMT;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vid_in_data <= 20'h0;
			frame_tick <= 1'b0;
			tc <= {5'h01, 6'h02, 6'h03, 6'h04};
		end else begin
			vid_in_data <= vid_in_data + 20'h1;
			frame_tick <= tick_req;
			tc.frames <= tc.frames + (tick_req ? 6'h1 : 6'h0);
		end
	end
endmodule // ffsrc_partner
`default_nettype wire

// ---- test/flat_field_and_timecode_source_test.sv ----
// self-checking bench for the flat field and timecode source
`default_nettype none
`include "ffsrc_defines.svh"
`define CHK(nm, exp, got) begin \
	compares++; \
	if ((got) !== (exp)) begin \
		n_mismatch++; \
		$display("wrong value %s expected %h seen %h", nm, exp, got); \
	end \
end
module flat_field_and_timecode_source_test;
	timeunit 1ns;
	timeprecision 1ps;
	import ffsrc_pkg::*;
	logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, rq;
	logic [1:0]  htrans = '0;
	logic        lock = 1'b1, tc_en = 1'b0, tick_req = 1'b0;
	int          n_mismatch = 0, compares = 0;
	wire logic   hreadyout, hresp, vid_in_valid, vid_out_valid, irq;
	wire logic   rx_locked, rx_format_known, frame_tick, ext_tc_valid;
	wire logic   flat_active;
	wire logic [31:0] hrdata;
	wire logic [19:0] vid_in_data, vid_out_data;
	wire logic [4:0]  rx_format, vid_out_format;
	wire timecode_t   ext_tc, tc_out;
	wire tc_src_t     tc_source;
	timecode_t        last;
	logic [19:0]      col [10];
	flat_field_and_timecode_source flat_field_and_timecode_source_i (
		.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .vid_in_data(vid_in_data),
		.vid_in_valid(vid_in_valid), .rx_locked(rx_locked),
		.rx_format_known(rx_format_known), .rx_format(rx_format),
		.frame_tick(frame_tick), .ext_tc_valid(ext_tc_valid),
		.ext_tc(ext_tc), .vid_out_data(vid_out_data),
		.vid_out_valid(vid_out_valid), .vid_out_format(vid_out_format),
		.flat_active(flat_active), .tc_out(tc_out),
		.tc_source(tc_source), .irq(irq));
	ffsrc_partner ffsrc_partner_i (.hclk(hclk), .hresetn(hresetn),
		.lock(lock), .tc_en(tc_en), .tick_req(tick_req),
		.vid_in_data(vid_in_data), .vid_in_valid(vid_in_valid),
		.rx_locked(rx_locked), .rx_format_known(rx_format_known),
		.rx_format(rx_format), .frame_tick(frame_tick),
		.ext_tc_valid(ext_tc_valid), .ext_tc(ext_tc));
	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] q);
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, rq);
	endtask
	task automatic rdchk(input string nm, input logic [7:0] a,
			input logic [31:0] e);
		xfer(1'b0, a, 32'h0, rq);
		`CHK(nm, e, rq)
	endtask
	task automatic settle;
		repeat (4) @(posedge hclk);
	endtask
	task automatic tick;
		tick_req <= 1'b1;
		@(posedge hclk);
		tick_req <= 1'b0;
		settle();
	endtask
	initial forever #2 hclk = ~hclk;
	initial begin
		repeat (5000) @(posedge hclk);
		n_mismatch++;
		report_and_stop();
	end
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdchk("ctrl", `OFF_CTRL, 32'h0);
		rdchk("status", `OFF_STATUS, 32'h2e);
		rdchk("unmapped", 8'h18, 32'h0);
		`CHK("hresp", 1'b0, hresp)
		$display("test reset done");
		lock <= 1'b0;
		wr(`OFF_CTRL, 32'h3);
		settle();
		`CHK("flat off", 1'b0, flat_active)
		wr(`OFF_CTRL, 32'h0);
		settle();
		`CHK("flat disabled", 1'b0, flat_active)
		wr(`OFF_CTRL, 32'h25);
		settle();
		`CHK("flat manual", 1'b1, flat_active)
		`CHK("flat format", 5'h09, vid_out_format)
		lock <= 1'b1;
		wr(`OFF_IRQ_STATUS, 32'h7);
		wr(`OFF_IRQ_MASK, 32'h2);
		`CHK("flat locked", 1'b1, flat_active)
		`CHK("flat format locked", 5'h09, vid_out_format)
		wr(`OFF_CTRL, 32'h2);
		settle();
		`CHK("flat pass", 1'b0, flat_active)
		`CHK("irq quiet", 1'b0, irq)
		lock <= 1'b0;
		settle();
		`CHK("flat loss", 1'b1, flat_active)
		`CHK("irq loss", 1'b1, irq)
		rdchk("status", `OFF_STATUS, 32'h29);
		wr(`OFF_IRQ_STATUS, 32'h7);
		settle();
		`CHK("irq clear", 1'b0, irq)
		for (int c = 0; c < 10; c++) begin
			wr(`OFF_CTRL, (c << 7) | 32'h1);
			settle();
			col[c] = vid_out_data;
			if (c > 0 && c < 9)
				`CHK("colour", 1'b1, col[c] !== col[c-1])
		end
		`CHK("colour spare", col[0], col[9])
		for (int a = 0; a < 9; a++)
			for (int b = a + 1; b < 9; b++)
				`CHK("colour distinct", 1'b1, col[a] !== col[b])
		$display("test flat field done");
		lock <= 1'b1;
		tc_en <= 1'b1;
		wr(`OFF_CTRL, 32'h4800);
		tick();
		`CHK("source input", SRC_INPUT, tc_source)
		`CHK("tc pass", ext_tc, tc_out)
		wr(`OFF_CTRL, 32'h7800);
		tick();
		`CHK("tc pass down", ext_tc, tc_out)
		wr(`OFF_PRESET, 32'h8000_1234);
		settle();
		`CHK("preset refused", ext_tc, tc_out)
		last = ext_tc;
		tc_en <= 1'b0;
		settle();
		`CHK("source free", SRC_FREE_RUN, tc_source)
		`CHK("tc seed", last, tc_out)
		wr(`OFF_PRESET, 32'h8000_0000);
		tick();
		`CHK("tc hold", 23'h0, tc_out)
		wr(`OFF_CTRL, 32'h5800);
		tick();
		`CHK("tc wrap", {5'h17, 6'h3b, 6'h3b, 6'h1d}, tc_out)
		wr(`OFF_CTRL, 32'h4800);
		tick();
		`CHK("tc roll", 23'h0, tc_out)
		wr(`OFF_PRESET, 32'h8000_0041);
		settle();
		`CHK("tc preset", 23'h41, tc_out)
		tick();
		`CHK("tc up", 23'h42, tc_out)
		wr(`OFF_CTRL, 32'h0800);
		settle();
		`CHK("source none", SRC_NONE, tc_source)
		$display("test timecode done");
		report_and_stop();
	end
endmodule // flat_field_and_timecode_source_test
`default_nettype wire
